// ### core/dfr_bank.sv
// result readback and read-with-reset bank for the per-pin extended functions
// assumes feature engines on the same clock, clearing on a feature reset pulse
`timescale 1ns/1ps
`default_nettype none

module dfr_bank (
  input  wire logic                                     clk_sys_in,
  input  wire logic                                     rst_n_in,
  // command-response port
  input  wire logic                                     cmd_valid_in,
  input  wire logic                                     cmd_write_in,
  input  wire logic [dfr_pkg::AW-1:0]                   cmd_addr_in,
  input  wire logic [dfr_pkg::DW-1:0]                   cmd_wdata_in,
  output logic                                          rsp_valid_out,
  output logic [dfr_pkg::DW-1:0]                        rsp_data_out,
  output logic                                          rsp_error_out,
  // stream scan port
  input  wire logic                                     strm_valid_in,
  output logic                                          strm_ready_out,
  input  wire logic [dfr_pkg::AW-1:0]                   strm_addr_in,
  output logic                                          strm_data_valid_out,
  input  wire logic                                     strm_data_ready_in,
  output logic [dfr_pkg::SW-1:0]                        strm_data_out,
  output logic                                          strm_error_out,
  // feature engines
  input  wire logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] int_a_result_in,
  input  wire logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] int_b_result_in,
  input  wire logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] float_result_in,
  output logic [dfr_pkg::NRES-1:0]                      feature_reset_out,
  output logic [dfr_pkg::NPIN-1:0][3:0]                 feature_code_out,
  output logic [dfr_pkg::NPIN-1:0]                      pair_claim_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [dfr_pkg::NPIN-1:0][31:0] sel;
    logic [dfr_pkg::NPIN-1:0][3:0]  code;
    logic [dfr_pkg::NPIN-1:0]       pair;
    logic                           rsp_valid;
    logic [31:0]                    rsp_data;
    logic                           rsp_error;
    logic [dfr_pkg::NRES-1:0]       freset;
    logic [15:0]                    capture;
  } dfr_bank_st_t;

  dfr_bank_st_t st;
  dfr_bank_st_t next_st;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [5:0] c_a;
  logic [5:0] c_b;
  logic [5:0] c_irc;
  logic [5:0] c_frc;
  logic [5:0] c_sel;
  logic [5:0] s_a;
  logic [5:0] s_b;
  logic [5:0] s_irc;
  logic       s_cap;
  logic       s_take;
  logic       fifo_ready;
  logic [16:0] s_word;

  assign c_a   = dfr_pkg::dfr_pick(cmd_addr_in, dfr_pkg::ADDR_RESULT_A, dfr_pkg::NRES_C);
  assign c_b   = dfr_pkg::dfr_pick(cmd_addr_in, dfr_pkg::ADDR_RESULT_B, dfr_pkg::NRES_C);
  assign c_irc = dfr_pkg::dfr_pick(cmd_addr_in, dfr_pkg::ADDR_INT_RC, dfr_pkg::NRES_C);
  assign c_frc = dfr_pkg::dfr_pick(cmd_addr_in, dfr_pkg::ADDR_FLOAT_RC, dfr_pkg::NRES_C);
  assign c_sel = dfr_pkg::dfr_pick(cmd_addr_in, dfr_pkg::ADDR_FEATURE_SEL, dfr_pkg::NPIN_C);
  assign s_a   = dfr_pkg::dfr_pick(strm_addr_in, dfr_pkg::ADDR_RESULT_A, dfr_pkg::NRES_C);
  assign s_b   = dfr_pkg::dfr_pick(strm_addr_in, dfr_pkg::ADDR_RESULT_B, dfr_pkg::NRES_C);
  assign s_irc = dfr_pkg::dfr_pick(strm_addr_in, dfr_pkg::ADDR_INT_RC, dfr_pkg::NRES_C);
  assign s_cap = (strm_addr_in == dfr_pkg::ADDR_CAPTURE_UPPER);
  assign s_take = strm_valid_in && fifo_ready;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] full_word;
    logic [4:0]  sp;
    logic        hit;
    full_word = dfr_pkg::RST_DATA;
    sp        = 5'h00;
    hit       = 1'b0;
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.freset    = '0;
    s_word            = 17'h10000;

    // command port carries every operation on its own except the capture entry read
    if (cmd_valid_in) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data  = dfr_pkg::RST_DATA;
      next_st.rsp_error = 1'b0;
      if (cmd_write_in) begin
        if (c_sel[5]) begin
          next_st.sel[c_sel[4:0]] = cmd_wdata_in;
        end else begin
          next_st.rsp_error = 1'b1;
        end
      end else if (c_a[5]) begin
        next_st.rsp_data = int_a_result_in[c_a[4:0]];
      end else if (c_b[5]) begin
        next_st.rsp_data = int_b_result_in[c_b[4:0]];
      end else if (c_irc[5]) begin
        // same value as the plain read, pre-reset, reset on the same edge
        next_st.rsp_data              = int_a_result_in[c_irc[4:0]];
        next_st.freset[c_irc[4:0]]    = 1'b1;
      end else if (c_frc[5]) begin
        // engine supplies the converted unit value
        next_st.rsp_data              = float_result_in[c_frc[4:0]];
        next_st.freset[c_frc[4:0]]    = 1'b1;
      end else if (c_sel[5]) begin
        next_st.rsp_data = st.sel[c_sel[4:0]];
      end else begin
        next_st.rsp_error = 1'b1;
      end
    end

    // stream entry: integer reads give the low half only
    if (s_a[5] || s_b[5] || s_irc[5]) begin
      hit = 1'b1;
      sp  = s_a[5] ? s_a[4:0] : (s_b[5] ? s_b[4:0] : s_irc[4:0]);
      full_word = s_b[5] ? int_b_result_in[sp] : int_a_result_in[sp];
    end
    if (s_cap) begin
      s_word = {1'b0, st.capture};
    end else if (hit && dfr_pkg::dfr_streamable(dfr_pkg::dfr_feat_t'(st.code[sp]))) begin
      s_word = {1'b0, full_word[15:0]};
      if (s_take) begin
        next_st.capture = full_word[31:16];
        if (s_irc[5]) begin
          next_st.freset[sp] = 1'b1;
        end
      end
    end

    // feature decode and pair claims follow the select registers
    for (int i = 0; i < int'(dfr_pkg::NPIN); i++) begin
      next_st.code[i] = 4'(dfr_pkg::dfr_decode(next_st.sel[i]));
      next_st.pair[i] = (next_st.code[i] == 4'(dfr_pkg::FEAT_LINE_LINE)) ||
                        (next_st.code[i] == 4'(dfr_pkg::FEAT_QUAD));
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st         <= '0;
      st.sel     <= {dfr_pkg::NPIN{dfr_pkg::RST_FEATURE_SEL}};
      st.code    <= '0;
      st.capture <= dfr_pkg::RST_CAPTURE;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // stream fifo, stalls the scan when the drain side stops
  // ------------------------------------------------------------
  dfr_fifo #(
    .WIDTH (17),
    .DEPTH (dfr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (strm_valid_in),
    .in_ready_out  (fifo_ready),
    .in_data_in    (s_word),
    .out_valid_out (strm_data_valid_out),
    .out_ready_in  (strm_data_ready_in),
    .out_data_out  ({strm_error_out, strm_data_out})
  );

  assign strm_ready_out    = fifo_ready;
  assign rsp_valid_out     = st.rsp_valid;
  assign rsp_data_out      = st.rsp_data;
  assign rsp_error_out     = st.rsp_error;
  assign feature_reset_out = st.freset;
  assign feature_code_out  = st.code;
  assign pair_claim_out    = st.pair;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_int_rc_value;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && !cmd_write_in && c_irc[5]) |=>
      (rsp_valid_out && !rsp_error_out && rsp_data_out == $past(int_a_result_in[c_irc[4:0]]) &&
       feature_reset_out[$past(c_irc[4:0])]);
  endproperty
  a_int_rc_value: assert property (p_int_rc_value) else $error("read-clear value wrong");

  property p_int_rc_reset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && !cmd_write_in && c_irc[5]) ##1 (!cmd_valid_in && !strm_valid_in) |=>
      !feature_reset_out[$past(c_irc[4:0], 2)];
  endproperty
  a_int_rc_reset: assert property (p_int_rc_reset) else $error("no one-cycle reset pulse");

  property p_float_rc;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && !cmd_write_in && c_frc[5]) |=>
      (rsp_data_out == $past(float_result_in[c_frc[4:0]]) && feature_reset_out[$past(c_frc[4:0])]);
  endproperty
  a_float_rc: assert property (p_float_rc) else $error("float read-clear wrong");

  property p_plain_no_reset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && !cmd_write_in && c_a[5] && !strm_valid_in) |=> (feature_reset_out == '0);
  endproperty
  a_plain_no_reset: assert property (p_plain_no_reset) else $error("plain read reset a feature");

  property p_unmapped;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && !cmd_write_in && !c_a[5] && !c_b[5] && !c_irc[5] && !c_frc[5] && !c_sel[5])
      |=> (rsp_valid_out && rsp_error_out);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  property p_stream_refuse;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_take && s_a[5] && !dfr_pkg::dfr_streamable(dfr_pkg::dfr_feat_t'(st.code[s_a[4:0]])))
      |-> s_word[16];
  endproperty
  a_stream_refuse: assert property (p_stream_refuse) else $error("unstreamable read accepted");

  property p_stream_halves;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_take && s_a[5] && !s_word[16]) |->
      (s_word[15:0] == int_a_result_in[s_a[4:0]][15:0])
      ##1 (st.capture == $past(int_a_result_in[s_a[4:0]][31:16]));
  endproperty
  a_stream_halves: assert property (p_stream_halves) else $error("stream halves mismatch");

  property p_select;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && cmd_write_in && c_sel[5] && cmd_wdata_in == 32'h0000_000A) |=>
      (feature_code_out[$past(c_sel[4:0])] == 4'hA && pair_claim_out[$past(c_sel[4:0])]);
  endproperty
  a_select: assert property (p_select) else $error("quadrature select not decoded");

  property p_pair;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (pair_claim_out[0] == (feature_code_out[0] == 4'h6 || feature_code_out[0] == 4'hA));
  endproperty
  a_pair: assert property (p_pair) else $error("pair claim inconsistent");

  property p_sel_readback;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && cmd_write_in && c_sel[5]) ##1 !cmd_valid_in ##1
      (cmd_valid_in && !cmd_write_in && cmd_addr_in == $past(cmd_addr_in, 2)) |=>
      (rsp_data_out == $past(cmd_wdata_in, 3));
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("select readback wrong");

  property p_rsp_follows;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rsp_valid_out |-> $past(cmd_valid_in);
  endproperty
  a_rsp_follows: assert property (p_rsp_follows) else $error("response without request");

  property p_write_refused;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && cmd_write_in && !c_sel[5]) |=>
      (rsp_valid_out && rsp_error_out && rsp_data_out == '0);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("bad write taken");

  property p_strm_rc_reset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_take && s_irc[5] && !s_word[16]) |=> feature_reset_out[$past(s_irc[4:0])];
  endproperty
  a_strm_rc_reset: assert property (p_strm_rc_reset) else $error("no stream reset");

  property p_strm_no_reset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_take && (s_a[5] || s_b[5]) && !cmd_valid_in) |=> (feature_reset_out == '0);
  endproperty
  a_strm_no_reset: assert property (p_strm_no_reset) else $error("stream read reset");

  property p_refused_keep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (s_take && s_word[16]) |=> $stable(st.capture);
  endproperty
  a_refused_keep: assert property (p_refused_keep) else $error("refused entry captured");

  property p_code_none;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cmd_valid_in && cmd_write_in && c_sel[5] && cmd_wdata_in > 32'h0000_000C) |=>
      (feature_code_out[$past(c_sel[4:0])] == 4'hF && !pair_claim_out[$past(c_sel[4:0])]);
  endproperty
  a_code_none: assert property (p_code_none) else $error("out-of-range select decoded");

endmodule

`default_nettype wire

// ### core/dfr_fifo.sv
// parameterised fifo with valid and ready on both sides
// assumes same clock on both sides; full and empty are registered
`timescale 1ns/1ps
`default_nettype none

module dfr_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
    logic          full;
    logic          empty;
  } dfr_fifo_st_t;

  dfr_fifo_st_t st;
  dfr_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push          = in_valid_in && !st.full;
  assign pop           = out_ready_in && !st.empty;
  assign in_ready_out  = !st.full;
  assign out_valid_out = !st.empty;
  assign out_data_out  = mem[st.rd];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt   = st.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    next_st.full  = (next_st.cnt == (PW+1)'(DEPTH));
    next_st.empty = (next_st.cnt == '0);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st       <= '0;
      st.empty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // storage kept out of reset on purpose: data only read when marked valid
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[st.wr] <= in_data_in;
    end
  end

endmodule

`default_nettype wire

// ### core/dfr_pkg.sv
// package for the pin feature result readback and read-with-reset bank
// assumes one core clock; feature engines sit outside and take the reset pulses
//
// Operation
// - integer read-clear returns the plain first result and pulses that pin's feature reset
// - float read-clear returns the 32-bit float result and pulses the feature reset
// - reset leaves the feature running; engines clear counts on the pulse
// - every read, reset and select access except the capture entry works on the command port alone
// - stream reads accepted only for frequency, width, counter and quadrature features
// - stream integer reads return low half; capture entry returns the upper half
// - feature select decodes to codes 0 to 12, frequency on 3 and 4
// - line-to-line and quadrature features also claim the next pin
// - float result register presents the engine's unit-converted value
// - per-pin 32-bit select register picks the feature the results follow

package dfr_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int unsigned NPIN       = 23;
  localparam int unsigned NRES       = 22;
  localparam int unsigned AW         = 16;
  localparam int unsigned DW         = 32;
  localparam int unsigned SW         = 16;
  localparam int unsigned FIFO_DEPTH = 32;

  localparam logic [4:0] NPIN_C = 5'h17;
  localparam logic [4:0] NRES_C = 5'h16;

  // ------------------------------------------------------------
  // register addresses, each 32-bit register spans two addresses
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_RESULT_A      = 16'h0BB8;
  localparam logic [15:0] ADDR_INT_RC        = 16'h0C1C;
  localparam logic [15:0] ADDR_RESULT_B      = 16'h0C80;
  localparam logic [15:0] ADDR_FLOAT_RC      = 16'h0E10;
  localparam logic [15:0] ADDR_FEATURE_SEL   = 16'hAC44;
  localparam logic [15:0] ADDR_CAPTURE_UPPER = 16'h1300;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_FEATURE_SEL = 32'h0000_0000;
  localparam logic [15:0] RST_CAPTURE     = 16'h0000;
  localparam logic [31:0] RST_DATA        = 32'h0000_0000;

  // ------------------------------------------------------------
  // feature codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FEAT_PWM        = 4'h0,
    FEAT_PWM_PHASE  = 4'h1,
    FEAT_PULSE_OUT  = 4'h2,
    FEAT_FREQ_RISE  = 4'h3,
    FEAT_FREQ_FALL  = 4'h4,
    FEAT_PULSE_W    = 4'h5,
    FEAT_LINE_LINE  = 4'h6,
    FEAT_HS_COUNT   = 4'h7,
    FEAT_IRQ_COUNT  = 4'h8,
    FEAT_DEB_COUNT  = 4'h9,
    FEAT_QUAD       = 4'hA,
    FEAT_IRQ_FREQ   = 4'hB,
    FEAT_COND_RESET = 4'hC,
    FEAT_NONE       = 4'hF
  } dfr_feat_t;

  // hit flag and pin index of an address against one per-pin block
  function automatic logic [5:0] dfr_pick(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic [4:0]  n);
    logic [15:0] d;
    d = a - b;
    return {(a >= b) && (d[0] == 1'b0) && (d[15:1] < {10'h000, n}), d[5:1]};
  endfunction

  function automatic dfr_feat_t dfr_decode(input logic [31:0] sel);
    dfr_feat_t f;
    f = FEAT_NONE;
    if (sel <= 32'h0000_000C) begin
      f = dfr_feat_t'(sel[3:0]);
    end
    return f;
  endfunction

  function automatic logic dfr_streamable(input dfr_feat_t f);
    logic s;
    s = 1'b0;
    case (f)
      FEAT_FREQ_RISE, FEAT_FREQ_FALL, FEAT_PULSE_W, FEAT_HS_COUNT,
      FEAT_IRQ_COUNT, FEAT_DEB_COUNT, FEAT_QUAD, FEAT_IRQ_FREQ: s = 1'b1;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

endpackage

// ### tb/dfr_engine_model.sv
// behavioural feature engines: per-pin counters that clear on a reset pulse
// assumes the bank's core clock and its active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module dfr_engine_model (
  input  wire logic                                      clk_sys_in,
  input  wire logic                                      rst_n_in,
  input  wire logic [dfr_pkg::NRES-1:0]                  feature_reset_in,
  output logic      [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] int_a_out,
  output logic      [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] int_b_out,
  output logic      [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] float_out
);
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] cnt;

  // upper half nonzero so a 16-bit split is visible
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dfr_pkg::NRES; i++) begin
        cnt[i] <= {8'h00, 8'(i + 1), 16'hFFFE};
      end
    end else begin
      for (int i = 0; i < dfr_pkg::NRES; i++) begin
        if (feature_reset_in[i]) begin
          cnt[i] <= 32'h0000_0000;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // results
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < dfr_pkg::NRES; i++) begin
      int_a_out[i] = cnt[i];
      int_b_out[i] = ~cnt[i];
      float_out[i] = cnt[i] ^ 32'h4000_0000; // stand-in unit conversion
    end
  end
endmodule

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the result readback bank
// assumes the engine model as far side; inputs driven on the falling edge
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                                      clk_sys_in;
  logic                                      rst_n_in;
  logic                                      cmd_valid;
  logic                                      cmd_write;
  logic [15:0]                               cmd_addr;
  logic [31:0]                               cmd_wdata;
  logic                                      strm_valid;
  logic [15:0]                               strm_addr;
  logic                                      strm_rdy;
  logic                                      rsp_valid_out;
  logic [31:0]                               rsp_data_out;
  logic                                      rsp_error_out;
  logic                                      strm_ready_out;
  logic                                      strm_data_valid_out;
  logic [15:0]                               strm_data_out;
  logic                                      strm_error_out;
  logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] res_a;
  logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] res_b;
  logic [dfr_pkg::NRES-1:0][dfr_pkg::DW-1:0] res_f;
  logic [dfr_pkg::NRES-1:0]                  feature_reset_out;
  logic [dfr_pkg::NPIN-1:0][3:0]             feature_code_out;
  logic [dfr_pkg::NPIN-1:0]                  pair_claim_out;
  logic [dfr_pkg::NRES-1:0]                  rst_seen;
  int                                        failures;
  int                                        num_checks;
  int                                        cycles;
  logic                                      strm_ok;

  dfr_bank u_dut (
    .clk_sys_in          (clk_sys_in),
    .rst_n_in            (rst_n_in),
    .cmd_valid_in        (cmd_valid),
    .cmd_write_in        (cmd_write),
    .cmd_addr_in         (cmd_addr),
    .cmd_wdata_in        (cmd_wdata),
    .rsp_valid_out       (rsp_valid_out),
    .rsp_data_out        (rsp_data_out),
    .rsp_error_out       (rsp_error_out),
    .strm_valid_in       (strm_valid),
    .strm_ready_out      (strm_ready_out),
    .strm_addr_in        (strm_addr),
    .strm_data_valid_out (strm_data_valid_out),
    .strm_data_ready_in  (strm_rdy),
    .strm_data_out       (strm_data_out),
    .strm_error_out      (strm_error_out),
    .int_a_result_in     (res_a),
    .int_b_result_in     (res_b),
    .float_result_in     (res_f),
    .feature_reset_out   (feature_reset_out),
    .feature_code_out    (feature_code_out),
    .pair_claim_out      (pair_claim_out)
  );

  dfr_engine_model u_eng (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .feature_reset_in (feature_reset_out),
    .int_a_out        (res_a),
    .int_b_out        (res_b),
    .float_out        (res_f)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] init_cnt(input int p);
    return {8'h00, 8'(p + 1), 16'hFFFE};
  endfunction

  function automatic logic [15:0] adr(input logic [15:0] base, input int p);
    return base + 16'(2 * p);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one request, response sampled in the cycle it stands
  task automatic cmd(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic eerr);
    @(negedge clk_sys_in);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr  = a;
    cmd_wdata = wd;
    @(negedge clk_sys_in);
    cmd_valid = 1'b0;
    rst_seen  = feature_reset_out;
    check({31'h0, rsp_valid_out}, 32'h1);
    check(rsp_data_out, exp);
    check({31'h0, rsp_error_out}, {31'h0, eerr});
  endtask

  // one-cycle entry; taken only if ready stands high
  task automatic push(input logic [15:0] a);
    @(negedge clk_sys_in);
    strm_valid = 1'b1;
    strm_addr  = a;
    @(negedge clk_sys_in);
    strm_valid = 1'b0;
  endtask

  task automatic pop(input logic [15:0] exp, input logic eerr);
    @(negedge clk_sys_in);
    check({31'h0, strm_data_valid_out}, 32'h1);
    check({15'h0, strm_error_out, strm_data_out}, {15'h0, eerr, exp});
    strm_rdy = 1'b1;
    @(negedge clk_sys_in);
    strm_rdy = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_write, strm_valid, strm_rdy} = 4'h0;
    cmd_addr   = 16'h0000;
    cmd_wdata  = 32'h0000_0000;
    strm_addr  = 16'h0000;
    failures   = 0;
    num_checks = 0;
    cycles     = 0;
    rst_n_in   = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    check({27'h0, feature_code_out[0], pair_claim_out[0]}, 32'h0);
    check({30'h0, strm_ready_out, strm_data_valid_out}, 32'h2);
    $display("test reset done");

    cmd(1'b0, adr(dfr_pkg::ADDR_RESULT_A, 3), 32'h0, init_cnt(3), 1'b0);
    check(32'(rst_seen), 32'h0);
    cmd(1'b0, adr(dfr_pkg::ADDR_RESULT_B, 3), 32'h0, ~init_cnt(3), 1'b0);
    cmd(1'b0, adr(dfr_pkg::ADDR_INT_RC, 3), 32'h0, init_cnt(3), 1'b0);
    check(32'(rst_seen), 32'h0000_0008);
    cmd(1'b0, adr(dfr_pkg::ADDR_RESULT_A, 3), 32'h0, 32'h0, 1'b0);
    cmd(1'b0, adr(dfr_pkg::ADDR_FLOAT_RC, 21), 32'h0, init_cnt(21) ^ 32'h4000_0000, 1'b0);
    check(32'(rst_seen), 32'h0020_0000);
    cmd(1'b0, adr(dfr_pkg::ADDR_RESULT_A, 21), 32'h0, 32'h0, 1'b0);
    cmd(1'b1, adr(dfr_pkg::ADDR_INT_RC, 4), 32'h1, 32'h0, 1'b1);
    cmd(1'b0, 16'h0BB9, 32'h0, 32'h0, 1'b1);
    cmd(1'b1, adr(dfr_pkg::ADDR_FEATURE_SEL, 22), 32'hC, 32'h0, 1'b0);
    cmd(1'b0, adr(dfr_pkg::ADDR_FEATURE_SEL, 22), 32'h0, 32'hC, 1'b0);
    cmd(1'b1, adr(dfr_pkg::ADDR_FEATURE_SEL, 23), 32'h1, 32'h0, 1'b1);
    $display("test command done");

    // every code, then out-of-range values that must decode to none
    for (int v = 0; v < 15; v++) begin
      cmd(1'b1, adr(dfr_pkg::ADDR_FEATURE_SEL, 2), 32'hFF, 32'h0, 1'b0); // disable first
      cmd(1'b1, adr(dfr_pkg::ADDR_FEATURE_SEL, 2), 32'(v), 32'h0, 1'b0);
      check({28'h0, feature_code_out[2]}, (v <= 12) ? 32'(v) : 32'hF);
      check({31'h0, pair_claim_out[2]}, {31'h0, (v == 6 || v == 10)});
      strm_ok = (v >= 3 && v <= 11 && v != 6);
      push(adr(dfr_pkg::ADDR_RESULT_A, 2));
      pop(strm_ok ? 16'hFFFE : 16'h0000, ~strm_ok);
    end
    $display("test select done");

    cmd(1'b1, adr(dfr_pkg::ADDR_FEATURE_SEL, 2), 32'h7, 32'h0, 1'b0);
    push(adr(dfr_pkg::ADDR_RESULT_A, 2));
    push(dfr_pkg::ADDR_CAPTURE_UPPER);
    push(adr(dfr_pkg::ADDR_RESULT_B, 2));
    push(dfr_pkg::ADDR_CAPTURE_UPPER);
    push(adr(dfr_pkg::ADDR_INT_RC, 2));
    pop(16'hFFFE, 1'b0);
    pop(16'h0003, 1'b0);
    pop(16'h0001, 1'b0);
    pop(16'hFFFC, 1'b0);
    pop(16'hFFFE, 1'b0);
    cmd(1'b0, adr(dfr_pkg::ADDR_RESULT_A, 2), 32'h0, 32'h0, 1'b0);
    $display("test stream done");

    // fill with the drain stalled, one extra entry must be refused
    repeat (33) push(adr(dfr_pkg::ADDR_RESULT_A, 2));
    check({31'h0, strm_ready_out}, 32'h0);
    repeat (32) pop(16'h0000, 1'b0);
    @(negedge clk_sys_in);
    check({30'h0, strm_ready_out, strm_data_valid_out}, 32'h2);
    $display("test fifo done");
    wrap_up();
  end
endmodule

`default_nettype wire
